// >>> logic/isp_pkg.sv
// Constants and types shared by the instrument serial port
`default_nettype none

package isp_pkg;

  // Clock and line rates
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_0 = 9600;
  localparam int BAUD_1 = 14400;
  localparam int BAUD_2 = 19200;
  localparam int BAUD_3 = 38400;
  localparam int BAUD_4 = 57600;
  localparam int BAUD_5 = 115200;
  // Cycles per bit, rounded to nearest
  localparam logic [11:0] DIV_0 = 12'((CLK_HZ + BAUD_0 / 2) / BAUD_0);
  localparam logic [11:0] DIV_1 = 12'((CLK_HZ + BAUD_1 / 2) / BAUD_1);
  localparam logic [11:0] DIV_2 = 12'((CLK_HZ + BAUD_2 / 2) / BAUD_2);
  localparam logic [11:0] DIV_3 = 12'((CLK_HZ + BAUD_3 / 2) / BAUD_3);
  localparam logic [11:0] DIV_4 = 12'((CLK_HZ + BAUD_4 / 2) / BAUD_4);
  localparam logic [11:0] DIV_5 = 12'((CLK_HZ + BAUD_5 / 2) / BAUD_5);

  // Frame layout
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [3:0] START_BITS = 4'h1;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_7 = 4'h7;

  // Receive buffer
  localparam int RX_AW = 16;
  localparam int RX_DEPTH = 65536;
  localparam logic [16:0] RX_STOP_LEVEL = 17'h0_FC00;
  localparam logic [16:0] RX_GO_LEVEL = 17'h0_F000;

  // Characters
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;

  // Register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_RXLEVEL = 8'h14;

  // Field positions
  localparam int CTL_REMOTE = 0;
  localparam int CTL_LOCAL = 1;
  localparam int CTL_CLEAR = 2;
  localparam int TX_EOM_BIT = 8;
  localparam int RX_VALID_BIT = 8;
  localparam int ST_OVERRUN = 5;
  localparam int ST_PARITY = 6;
  localparam int ST_FRAME = 7;
  localparam int ST_BREAK = 8;

  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} isp_parity_e;
  typedef enum logic [1:0] {PACING_CMD_NONE, PACING_CMD_XON, PACING_CMD_HW} isp_pacing_cmd_e;
  typedef enum logic [1:0] {TERM_CR, TERM_LF, TERM_CRLF} isp_term_e;

  typedef struct packed {
    isp_term_e term;
    isp_pacing_cmd_e pacing_cmd;
    logic stop2;
    isp_parity_e parity;
    logic len8;
    logic [2:0] rate;
  } isp_cfg_s;

  // 9600, 8 data bits, no parity, 1 stop, no pacing, CR+LF
  localparam logic [10:0] CFG_RESET = 11'h408;

  // Reset levels of synchronised pins {localKey, cts, rxd}
  localparam logic [2:0] PIN_IDLE = 3'h3;

endpackage

`default_nettype wire

// >>> logic/isp_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`default_nettype none

module isp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage1;

  // Only the second stage is visible outside
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      dout <= INIT;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // isp_sync

`default_nettype wire

// >>> logic/isp_serial_port.sv
// Instrument serial port: UART with pacing, terminators, break, remote
//
// Contract
// [R1] Six selectable line rates, both ends match
// [R2] Seven or eight data bits per frame
// [R3] Parity none, even or odd
// [R4] One or two stop bits
// [R5] Pacing none, character or line handshake
// [R6] Sixty-four kilobyte receive buffer
// [R7] Line pacing drops flow output before full
// [R8] Line pacing pauses sending while peer false
// [R9] Character pacing sends pause before full
// [R10] Character pacing sends resume when space frees
// [R11] Pacing codes cannot carry payload bytes
// [R12] Unpaced host keeps commands within buffer
// [R13] Transmit terminator CR, LF or CR+LF
// [R14] Receive accepts any terminator form
// [R15] Received break acts as device clear
// [R16] Clear flushes input, output, ends wait
// [R17] Remote command enters remote, locks keys
// [R18] Remote indicator follows remote mode
// [R19] Local key or command returns local
// [R20] Mode changes keep all settings
// [R21] Start low, LSB first, parity, stops high
// [R22] Break is low longer than frame
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`default_nettype none

module isp_serial_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxdPin,
  output logic txdPin,
  input wire logic ctsPin,
  output logic rtsPin,
  input wire logic localKeyPin,
  output logic remoteLed,
  output logic keyLockout,
  output logic deviceClear
);

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} isp_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} isp_rx_e;

  logic rxd;
  logic cts;
  logic localKey;
  logic localKeyPrev;

  isp_sync #(.W(3), .INIT(isp_pkg::PIN_IDLE)) pinSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({localKeyPin, ctsPin, rxdPin}),
    .dout({localKey, cts, rxd})
  );

  // Configuration survives mode changes and device clear
  isp_pkg::isp_cfg_s cfg;
  logic remote;

  // APB decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire selCfg = paddr == isp_pkg::ADDR_CFG;
  wire selSt = paddr == isp_pkg::ADDR_STATUS;
  wire selTx = paddr == isp_pkg::ADDR_TXDATA;
  wire selRx = paddr == isp_pkg::ADDR_RXDATA;
  wire selCtl = paddr == isp_pkg::ADDR_CTRL;
  wire selLvl = paddr == isp_pkg::ADDR_RXLEVEL;
  wire mapped = selCfg | selSt | selTx | selRx | selCtl | selLvl;

  // Line rate selection
  logic [11:0] bitDiv;
  always_comb begin
    case (cfg.rate) // R1
      3'h1: bitDiv = isp_pkg::DIV_1;
      3'h2: bitDiv = isp_pkg::DIV_2;
      3'h3: bitDiv = isp_pkg::DIV_3;
      3'h4: bitDiv = isp_pkg::DIV_4;
      3'h5: bitDiv = isp_pkg::DIV_5;
      default: bitDiv = isp_pkg::DIV_0;
    endcase
  end
  wire [2:0] lastBit = cfg.len8 ? isp_pkg::LAST_BIT_8
                                 : isp_pkg::LAST_BIT_7; // R2
  wire hasParity = cfg.parity != isp_pkg::PAR_NONE;
  wire [3:0] frameBits = isp_pkg::START_BITS
    + (cfg.len8 ? isp_pkg::DATA_BITS_8 : isp_pkg::DATA_BITS_7)
    + {3'h0, hasParity} + {3'h0, cfg.stop2} + 4'h1;
  wire [15:0] frameCycles = 16'(frameBits * bitDiv);

  // Receive buffer state
  logic [7:0] rxMem [isp_pkg::RX_DEPTH];
  logic [isp_pkg::RX_AW-1:0] wrPtr;
  logic [isp_pkg::RX_AW-1:0] rdPtr;
  logic [16:0] rxLevel;
  logic rxThrottle;
  logic hostXoff;
  logic lastWasCr;
  logic xoffPend;
  logic xonPend;

  // Transmit holding and engine state
  logic txHoldValid;
  logic [7:0] txHoldData;
  logic txHoldEom;
  logic [1:0] termPend;
  isp_tx_e txState;
  logic [11:0] txCnt;
  logic [2:0] txBit;
  logic [7:0] txShift;
  logic txAcc;
  logic txStopIdx;

  // Receive engine state
  isp_rx_e rxState;
  logic [11:0] rxCnt;
  logic [2:0] rxBit;
  logic [7:0] rxShift;
  logic rxAcc;
  logic rxStopIdx;
  logic rxBad;
  logic rxGot;
  logic [7:0] rxByte;
  logic [15:0] brkCnt;

  logic overrun;
  logic parityErr;
  logic frameErr;
  logic breakSeen;

  // Pacing codes refused as payload
  wire txIsFlow = cfg.pacing_cmd == isp_pkg::PACING_CMD_XON
    & (pwdata[7:0] == isp_pkg::CHAR_XON
       | pwdata[7:0] == isp_pkg::CHAR_XOFF); // R11
  wire txRefuse = txHoldValid | txIsFlow;

  // Events
  wire breakHit = ~rxd & brkCnt == frameCycles; // R22
  wire clrEvt = breakHit
    | (wr & selCtl & pwdata[isp_pkg::CTL_CLEAR]); // R15
  wire remoteCmd = wr & selCtl & pwdata[isp_pkg::CTL_REMOTE];
  wire localCmd = wr & selCtl & pwdata[isp_pkg::CTL_LOCAL];
  wire keyPress = localKey & ~localKeyPrev;

  // Transmit selection, flow characters first
  wire txTick = txCnt == bitDiv - 12'h001;
  wire txPaused = (cfg.pacing_cmd == isp_pkg::PACING_CMD_HW & ~cts)
    | (cfg.pacing_cmd == isp_pkg::PACING_CMD_XON & hostXoff); // R8
  wire flowGo = xoffPend | xonPend;
  wire termGo = ~txPaused & termPend != 2'h0;
  wire dataGo = ~txPaused & txHoldValid & termPend == 2'h0;
  wire txLoad = txState == TX_IDLE & (flowGo | termGo | dataGo);
  wire [7:0] termChar = termPend == 2'h2 ? isp_pkg::CHAR_LF
                                         : isp_pkg::CHAR_CR;
  wire [7:0] flowChar = xoffPend ? isp_pkg::CHAR_XOFF
                                 : isp_pkg::CHAR_XON; // R9 R10
  wire [7:0] txPick = flowGo ? flowChar : termGo ? termChar : txHoldData;

  // Receive path decisions
  wire rxTick = rxCnt == bitDiv - 12'h001;
  wire rxHalf = rxCnt == {1'b0, bitDiv[11:1]};
  wire [7:0] rxData = cfg.len8 ? rxShift : {1'b0, rxShift[7:1]};
  wire rxPaceChar = cfg.pacing_cmd == isp_pkg::PACING_CMD_XON
    & (rxByte == isp_pkg::CHAR_XON | rxByte == isp_pkg::CHAR_XOFF);
  wire rxIsTerm = rxByte == isp_pkg::CHAR_CR
    | rxByte == isp_pkg::CHAR_LF;
  wire rxPairLf = rxByte == isp_pkg::CHAR_LF & lastWasCr; // R14
  wire rxStore = rxGot & ~rxPaceChar & ~rxPairLf;
  wire rxFull = rxLevel == 17'(isp_pkg::RX_DEPTH); // R6
  wire push = rxStore & ~rxFull;
  wire pop = rd & selRx & prdata[isp_pkg::RX_VALID_BIT];
  // Terminators are stored as LF so software sees one form
  wire [7:0] storeByte = rxIsTerm ? isp_pkg::CHAR_LF : rxByte; // R14

  // Read mux
  wire [31:0] stWord = {22'h00_0000, cts, breakSeen, frameErr, parityErr,
    overrun, rxThrottle, hostXoff, txState != TX_IDLE, txHoldValid,
    rxLevel != 17'h0_0000};
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (selCfg) rdMux = {21'h00_0000, cfg};
    if (selSt) rdMux = stWord;
    if (selRx) rdMux = {23'h00_0000, rxLevel != 17'h0_0000,
                        rxLevel != 17'h0_0000 ? rxMem[rdPtr] : 8'h00};
    if (selCtl) rdMux = {31'h0000_0000, remote};
    if (selLvl) rdMux = {15'h0000, rxLevel};
  end

  // APB slave answers one cycle after setup
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & (~mapped | (pwrite & selTx & txRefuse));
      prdata <= (setup & ~pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // Configuration, mode and clear pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg <= isp_pkg::isp_cfg_s'(isp_pkg::CFG_RESET);
      remote <= 1'b0;
      remoteLed <= 1'b0;
      keyLockout <= 1'b0;
      localKeyPrev <= 1'b0;
      deviceClear <= 1'b0;
    end else begin
      if (wr & selCfg) cfg <= isp_pkg::isp_cfg_s'(pwdata[10:0]); // R5
      localKeyPrev <= localKey;
      // Local wins if both arrive together; cfg is untouched
      if (localCmd | keyPress) begin // R19 R20
        remote <= 1'b0;
        remoteLed <= 1'b0; // R18
        keyLockout <= 1'b0;
      end else if (remoteCmd) begin // R17
        remote <= 1'b1;
        remoteLed <= 1'b1; // R18
        keyLockout <= 1'b1;
      end
      deviceClear <= clrEvt; // R16
    end
  end

  // Transmit holding register and terminator queue
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txHoldValid <= 1'b0;
      txHoldData <= 8'h00;
      txHoldEom <= 1'b0;
      termPend <= 2'h0;
    end else if (clrEvt) begin // R16
      txHoldValid <= 1'b0;
      txHoldEom <= 1'b0;
      termPend <= 2'h0;
    end else begin
      if (wr & selTx & ~pslverr) begin
        txHoldValid <= 1'b1;
        txHoldData <= pwdata[7:0];
        txHoldEom <= pwdata[isp_pkg::TX_EOM_BIT];
      end else if (txLoad & dataGo & ~flowGo) begin
        txHoldValid <= 1'b0;
        if (txHoldEom) begin // R13
          termPend <= cfg.term == isp_pkg::TERM_LF ? 2'h2 : 2'h1;
        end
      end else if (txLoad & termGo & ~flowGo) begin
        termPend <= (termPend == 2'h1 & cfg.term == isp_pkg::TERM_CRLF)
                    ? 2'h2 : 2'h0; // R13
      end
    end
  end

  // Transmit frame engine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txState <= TX_IDLE;
      txdPin <= 1'b1;
      txCnt <= 12'h000;
      txBit <= 3'h0;
      txShift <= 8'h00;
      txAcc <= 1'b0;
      txStopIdx <= 1'b0;
    end else begin
      txCnt <= (txState == TX_IDLE | txTick) ? 12'h000 : txCnt + 12'h001;
      case (txState)
        TX_IDLE: if (txLoad) begin
          txShift <= txPick;
          txdPin <= 1'b0; // R21
          txState <= TX_START;
        end
        TX_START: if (txTick) begin
          txdPin <= txShift[0]; // R21
          txAcc <= txShift[0];
          txShift <= {1'b0, txShift[7:1]};
          txBit <= 3'h0;
          txState <= TX_DATA;
        end
        TX_DATA: if (txTick) begin
          if (txBit == lastBit) begin // R2
            txStopIdx <= 1'b0;
            if (hasParity) begin // R3
              txdPin <= cfg.parity == isp_pkg::PAR_ODD ? ~txAcc : txAcc;
              txState <= TX_PAR;
            end else begin
              txdPin <= 1'b1;
              txState <= TX_STOP;
            end
          end else begin
            txdPin <= txShift[0];
            txAcc <= txAcc ^ txShift[0];
            txShift <= {1'b0, txShift[7:1]};
            txBit <= txBit + 3'h1;
          end
        end
        TX_PAR: if (txTick) begin
          txdPin <= 1'b1;
          txState <= TX_STOP;
        end
        TX_STOP: if (txTick) begin
          if (cfg.stop2 & ~txStopIdx) txStopIdx <= 1'b1; // R4
          else txState <= TX_IDLE;
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // Receive frame engine, sampling at mid-bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxState <= RX_IDLE;
      rxCnt <= 12'h000;
      rxBit <= 3'h0;
      rxShift <= 8'h00;
      rxAcc <= 1'b0;
      rxStopIdx <= 1'b0;
      rxBad <= 1'b0;
      rxGot <= 1'b0;
      rxByte <= 8'h00;
    end else begin
      rxGot <= 1'b0;
      rxCnt <= (rxState == RX_IDLE | rxTick | (rxState == RX_START & rxHalf))
               ? 12'h000 : rxCnt + 12'h001;
      case (rxState)
        RX_IDLE: if (~rxd) rxState <= RX_START; // R21
        RX_START: if (rxHalf) begin
          rxState <= rxd ? RX_IDLE : RX_DATA;
          rxBit <= 3'h0;
          rxAcc <= 1'b0;
          rxBad <= 1'b0;
        end
        RX_DATA: if (rxTick) begin
          rxShift <= {rxd, rxShift[7:1]}; // R21
          rxAcc <= rxAcc ^ rxd;
          rxBit <= rxBit + 3'h1;
          rxStopIdx <= 1'b0;
          if (rxBit == lastBit) rxState <= hasParity ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rxTick) begin
          rxBad <= (rxAcc ^ rxd) != (cfg.parity == isp_pkg::PAR_ODD); // R3
          rxState <= RX_STOP;
        end
        RX_STOP: if (rxTick) begin
          if (~rxd) begin
            // Framing error drops the byte; a break starts this way
            rxState <= RX_IDLE;
          end else if (cfg.stop2 & ~rxStopIdx) begin // R4
            rxStopIdx <= 1'b1;
          end else begin
            rxState <= RX_IDLE;
            rxGot <= ~rxBad;
            rxByte <= rxData;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Break timer counts low line time, stopping once past one frame
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      brkCnt <= 16'h0000;
    end else if (rxd) begin
      brkCnt <= 16'h0000;
    end else if (brkCnt <= frameCycles) begin // R22
      brkCnt <= brkCnt + 16'h0001;
    end
  end

  // Sticky errors, set wins over a write-one clear
  wire frameEvt = rxState == RX_STOP & rxTick & ~rxd;
  wire parityEvt = rxState == RX_STOP & rxTick & rxd & rxBad
    & ~(cfg.stop2 & ~rxStopIdx);
  wire [3:0] stClr = {4{wr & selSt}} & pwdata[isp_pkg::ST_BREAK:
                                              isp_pkg::ST_OVERRUN];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      overrun <= 1'b0;
      parityErr <= 1'b0;
      frameErr <= 1'b0;
      breakSeen <= 1'b0;
    end else begin
      overrun <= (rxStore & rxFull) | (overrun & ~stClr[0]);
      parityErr <= parityEvt | (parityErr & ~stClr[1]);
      frameErr <= frameEvt | (frameErr & ~stClr[2]);
      breakSeen <= breakHit | (breakSeen & ~stClr[3]);
    end
  end

  // Receive buffer storage; no reset needed on the array
  always_ff @(posedge clk_sys) begin
    if (push) rxMem[wrPtr] <= storeByte;
  end

  // Receive buffer pointers, pacing state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      rxLevel <= 17'h0_0000;
      lastWasCr <= 1'b0;
      hostXoff <= 1'b0;
    end else if (clrEvt) begin // R16
      wrPtr <= '0;
      rdPtr <= '0;
      rxLevel <= 17'h0_0000;
      lastWasCr <= 1'b0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      rxLevel <= rxLevel + {16'h0000, push} - {16'h0000, pop};
      if (rxGot) lastWasCr <= rxByte == isp_pkg::CHAR_CR;
      if (rxGot & rxPaceChar) begin // R8 R11
        hostXoff <= rxByte == isp_pkg::CHAR_XOFF;
      end
      if (cfg.pacing_cmd != isp_pkg::PACING_CMD_XON) hostXoff <= 1'b0;
    end
  end

  // Hysteresis keeps the flow output from chattering near full
  wire throttleOn = rxLevel >= isp_pkg::RX_STOP_LEVEL;
  wire throttleOff = rxLevel <= isp_pkg::RX_GO_LEVEL;
  wire sentFlow = txLoad & flowGo;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxThrottle <= 1'b0;
      xoffPend <= 1'b0;
      xonPend <= 1'b0;
      rtsPin <= 1'b1;
    end else begin
      if (throttleOn) rxThrottle <= 1'b1;
      else if (throttleOff) rxThrottle <= 1'b0;
      if (cfg.pacing_cmd != isp_pkg::PACING_CMD_XON) begin
        xoffPend <= 1'b0;
        xonPend <= 1'b0;
      end else if (throttleOn & ~rxThrottle) begin // R9
        xoffPend <= 1'b1;
        xonPend <= 1'b0;
      end else if (throttleOff & rxThrottle) begin // R10
        xonPend <= 1'b1;
        xoffPend <= 1'b0;
      end else if (sentFlow) begin
        xoffPend <= 1'b0;
        xonPend <= xoffPend ? xonPend : 1'b0;
      end
      rtsPin <= cfg.pacing_cmd == isp_pkg::PACING_CMD_HW
        ? ~(throttleOn | (rxThrottle & ~throttleOff)) : 1'b1; // R7
    end
  end

endmodule // isp_serial_port

`default_nettype wire

// >>> testbench/isp_serial_port_asserts.sv
// Port-level assertions for the instrument serial port
`default_nettype none

module isp_serial_port_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txdPin,
  input wire logic localKeyPin,
  input wire logic remoteLed,
  input wire logic keyLockout,
  input wire logic deviceClear
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  wire ctrlWr = psel && penable && pready && pwrite &&
    paddr == isp_pkg::ADDR_CTRL;
  // Length of the current low run on the transmit line
  logic [11:0] lowRun;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) lowRun <= 12'h000;
    else if (txdPin) lowRun <= 12'h000;
    else if (lowRun != 12'hFFF) lowRun <= lowRun + 12'h001;
  end

  AST_SETUP_READY: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED: assert property (psel && !penable &&
    paddr > isp_pkg::ADDR_RXLEVEL |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address accepted");
  AST_LED_LOCK: assert property (remoteLed == keyLockout)
    else $error("indicator and lockout differ");
  AST_REMOTE_CMD: assert property (ctrlWr && pwdata[1:0] == 2'b01
    |-> ##[1:2] remoteLed) else $error("remote entry missed");
  AST_LOCAL_CMD: assert property (ctrlWr && pwdata[1]
    |-> ##[1:2] !remoteLed) else $error("local entry missed");
  AST_LOCAL_KEY: assert property ($rose(localKeyPin)
    |-> ##[1:5] !remoteLed) else $error("local key ignored");
  AST_CLEAR_PULSE: assert property (deviceClear |=> !deviceClear)
    else $error("clear pulse too long");
  AST_CLEAR_CMD: assert property (ctrlWr && pwdata[2]
    |-> ##[1:3] deviceClear) else $error("clear command lost");
  // Fastest rate gives 217 cycles a bit; one cycle kept for sampling
  AST_TX_BIT_LEN: assert property ($rose(txdPin)
    |-> lowRun >= 12'd216) else $error("low bit too short");

  COV_REMOTE: cover property (ctrlWr && pwdata[1:0] == 2'b01);
  COV_CLEAR: cover property (deviceClear);
  COV_ERR: cover property (pslverr);
endmodule // isp_serial_port_asserts

bind isp_serial_port isp_serial_port_asserts i_isp_serial_port_asserts (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txdPin(txdPin),
  .localKeyPin(localKeyPin), .remoteLed(remoteLed),
  .keyLockout(keyLockout), .deviceClear(deviceClear)
);

`default_nettype wire

// >>> testbench/isp_host_model.sv
// Behavioural host serial port facing the instrument
`default_nettype none

module isp_host_model (
  input wire logic clk_sys,
  input wire logic txdPin,
  input wire logic rtsPin,
  output logic rxdPin
);
  timeunit 1ns;
  timeprecision 1ns;
  int bitCyc = 217;
  int nData = 8;
  int parMode = 0;
  int nStop = 1;
  int nBad = 0;
  logic [7:0] got[$];

  initial rxdPin = 1'b1;

  task automatic setFmt(input int nd, input int pm, input int ns);
    nData = nd;
    parMode = pm;
    nStop = ns;
  endtask

  task automatic bitOut(input logic v);
    rxdPin <= v;
    repeat (bitCyc) @(posedge clk_sys);
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] d;
    d = (nData == 8) ? b : {1'b0, b[6:0]};
    while (rtsPin !== 1'b1) @(posedge clk_sys);
    bitOut(1'b0);
    for (int i = 0; i < nData; i++) bitOut(d[i]);
    if (parMode != 0) bitOut(^d ^ (parMode == 2));
    for (int i = 0; i < nStop; i++) bitOut(1'b1);
  endtask

  // Low well past one whole frame
  task automatic brk();
    rxdPin <= 1'b0;
    repeat (bitCyc * 14) @(posedge clk_sys);
    bitOut(1'b1);
  endtask

  initial forever begin : rxLoop
    logic [7:0] b;
    do @(posedge clk_sys); while (txdPin !== 1'b0);
    repeat (bitCyc / 2) @(posedge clk_sys);
    b = 8'h00;
    for (int i = 0; i < nData; i++) begin
      repeat (bitCyc) @(posedge clk_sys);
      b[i] = txdPin;
    end
    if (parMode != 0) begin
      repeat (bitCyc) @(posedge clk_sys);
      if (txdPin !== (^b ^ (parMode == 2))) nBad++;
    end
    for (int i = 0; i < nStop; i++) begin
      repeat (bitCyc) @(posedge clk_sys);
      if (txdPin !== 1'b1) nBad++;
    end
    got.push_back(b);
  end
endmodule // isp_host_model

`default_nettype wire

// >>> testbench/isp_serial_port_tb.sv
// Self-checking bench for the instrument serial port
`default_nettype none

module isp_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ctsPin = 1'b1;
  logic localKeyPin = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rxdPin, txdPin, rtsPin, rerr;
  logic remoteLed, keyLockout, deviceClear;
  logic [7:0] eq[$];
  logic [10:0] cfgTab[4] = '{11'h05D, 11'h25D, 11'h45D, 11'h025};
  int nFail = 0;
  int checks = 0;
  int dcCount = 0;

  isp_serial_port i_isp_serial_port (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxdPin(rxdPin), .txdPin(txdPin),
    .ctsPin(ctsPin), .rtsPin(rtsPin), .localKeyPin(localKeyPin),
    .remoteLed(remoteLed), .keyLockout(keyLockout),
    .deviceClear(deviceClear));
  isp_host_model i_isp_host_model (.clk_sys(clk_sys), .txdPin(txdPin),
    .rtsPin(rtsPin), .rxdPin(rxdPin));

  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (deviceClear === 1'b1) dcCount++;

  task automatic stopTest();
    if (nFail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Master holds the whole request until ready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  task automatic waitRx(input int n);
    for (int k = 0; k < 20000 && i_isp_host_model.got.size() < n; k++)
      @(posedge clk_sys);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    chk(32'({remoteLed, txdPin, rtsPin, deviceClear}), 32'h0000_0006);
    rst <= 1'b0;
    rd(isp_pkg::ADDR_CFG, 32'(isp_pkg::CFG_RESET));
    for (int i = 0; i < 4; i++) begin
      i_isp_host_model.setFmt(i < 3 ? 8 : 7, i < 3 ? 1 : 2, i < 3 ? 2 : 1);
      i_isp_host_model.got.delete();
      eq = '{8'h5A};
      if (i == 0 || i == 2) eq.push_back(isp_pkg::CHAR_CR);
      if (i == 1 || i == 2) eq.push_back(isp_pkg::CHAR_LF);
      apb(1'b1, isp_pkg::ADDR_CFG, 32'(cfgTab[i]));
      apb(1'b1, isp_pkg::ADDR_TXDATA, {23'h0, i < 3, 8'h5A});
      waitRx(eq.size());
      foreach (eq[k]) chk(32'(i_isp_host_model.got[k]), 32'(eq[k]));
    end
    chk(i_isp_host_model.nBad, 0);
    // Lone CR, then CR+LF, then lone LF
    i_isp_host_model.send(8'h41);
    i_isp_host_model.send(isp_pkg::CHAR_CR);
    i_isp_host_model.send(isp_pkg::CHAR_CR);
    i_isp_host_model.send(isp_pkg::CHAR_LF);
    i_isp_host_model.send(isp_pkg::CHAR_LF);
    repeat (20) @(posedge clk_sys);
    rd(isp_pkg::ADDR_RXLEVEL, 32'h0000_0004);
    rd(isp_pkg::ADDR_RXDATA, 32'h0000_0141);
    for (int k = 0; k < 3; k++) rd(isp_pkg::ADDR_RXDATA, 32'h0000_010A);
    rd(isp_pkg::ADDR_RXDATA, 32'h0000_0000);
    i_isp_host_model.send(8'h42);
    i_isp_host_model.brk();
    repeat (20) @(posedge clk_sys);
    rd(isp_pkg::ADDR_RXLEVEL, 32'h0000_0000);
    chk(dcCount, 1);
    apb(1'b0, isp_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(32'(rdat[isp_pkg::ST_BREAK]), 32'h0000_0001);
    apb(1'b1, isp_pkg::ADDR_CTRL, 32'h0000_0004);
    repeat (4) @(posedge clk_sys);
    chk(dcCount, 2);
    apb(1'b1, isp_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    chk(32'({keyLockout, remoteLed}), 32'h0000_0003);
    rd(isp_pkg::ADDR_CFG, 32'h0000_0025);
    localKeyPin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    localKeyPin <= 1'b0;
    chk(32'({keyLockout, remoteLed}), 32'h0000_0000);
    apb(1'b1, isp_pkg::ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, isp_pkg::ADDR_CTRL, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    chk(32'(remoteLed), 32'h0000_0000);
    // Pacing codes refused as payload, plain byte accepted
    apb(1'b1, isp_pkg::ADDR_CFG, 32'h0000_00A5);
    eq = '{isp_pkg::CHAR_XON, isp_pkg::CHAR_XOFF, 8'h20};
    foreach (eq[k]) begin
      apb(1'b1, isp_pkg::ADDR_TXDATA, {24'h0, eq[k]});
      chk(32'(rerr), 32'(k < 2));
    end
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({rdat[30:0], rerr}, 32'h0000_0001);
    i_isp_host_model.got.delete();
    waitRx(1);
    chk(32'(i_isp_host_model.got.pop_front()), 32'h0000_0020);
    apb(1'b1, isp_pkg::ADDR_CFG, 32'h0000_0125);
    ctsPin <= 1'b0;
    apb(1'b1, isp_pkg::ADDR_TXDATA, 32'h0000_0033);
    repeat (3000) @(posedge clk_sys);
    chk(i_isp_host_model.got.size(), 0);
    chk(32'(rtsPin), 32'h0000_0001);
    ctsPin <= 1'b1;
    waitRx(1);
    chk(32'(i_isp_host_model.got[0]), 32'h0000_0033);
    stopTest();
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    nFail++;
    stopTest();
  end
endmodule // isp_serial_port_tb

`default_nettype wire
